// file: hdl/tbus_pkg.sv
// constants and types shared by the device end and the far end of the link
// assumes one 100 MHz clock and synchronous active high reset at both ends
package tbus_pkg;

  // ***************************************************
  // clock and timing
  // ***************************************************
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int REF_CLK_FREQ_KHZ = 19440;
  localparam int FRAME_RATE_HZ = 8000;
  localparam int FRAME_PERIOD_CYCLES = (CLK_FREQ_KHZ * 1000) / FRAME_RATE_HZ;
  localparam int NCO_WIDTH = 17;
  localparam logic [NCO_WIDTH-1:0] REF_NCO_INC = NCO_WIDTH'(2 * REF_CLK_FREQ_KHZ);
  localparam logic [NCO_WIDTH:0] REF_NCO_MOD = (NCO_WIDTH + 1)'(CLK_FREQ_KHZ);
  localparam logic [NCO_WIDTH-1:0] REF_NCO_RESET = 17'h00000;
  localparam logic [3:0] SLOW_CLK_HALF_CYCLES = 4'h2;

  // ***************************************************
  // data path
  // ***************************************************
  localparam int RAIL_WIDTH = 2;
  localparam int FIFO_DEPTH = 8;
  localparam logic [RAIL_WIDTH-1:0] RAIL_IDLE = 2'h0;

  // ***************************************************
  // pin roles
  // ***************************************************
  typedef enum logic [3:0] {
    ROLE_IDLE    = 4'b0001,
    ROLE_BUS     = 4'b0010,
    ROLE_INSERT  = 4'b0100,
    ROLE_EXTRACT = 4'b1000
  } role_t;

endpackage : tbus_pkg

// file: hdl/tx_bus_link_if.sv
// shared pins between device end and far end, with their resolved levels
// assumes each end raises its enable only while it drives the pin
`timescale 1ns/1ps
interface tx_bus_link_if;
  logic refPosDevOut;
  logic refPosDevOe;
  logic posFarOut;
  logic posFarOe;
  logic negDevOut;
  logic negDevOe;
  logic negFarOut;
  logic negFarOe;
  logic clkDevOut;
  logic clkDevOe;
  logic clkFarOut;
  logic clkFarOe;
  logic fpDevOut;
  logic fpDevOe;
  logic posLine;
  logic negLine;
  logic clkLine;
  logic fpLine;

  // ***************************************************
  // wire levels
  // ***************************************************
  assign posLine = refPosDevOe ? refPosDevOut : (posFarOe ? posFarOut : 1'b0);
  assign negLine = negDevOe ? negDevOut : (negFarOe ? negFarOut : 1'b0);
  assign clkLine = clkDevOe ? clkDevOut : (clkFarOe ? clkFarOut : 1'b0);
  assign fpLine = fpDevOe ? fpDevOut : 1'b0;

  modport device (
    output refPosDevOut, refPosDevOe, negDevOut, negDevOe,
    output clkDevOut, clkDevOe, fpDevOut, fpDevOe,
    input posLine, negLine, clkLine
  );
  modport far (
    output posFarOut, posFarOe, negFarOut, negFarOe, clkFarOut, clkFarOe,
    input posLine, negLine, clkLine, fpLine
  );
endinterface : tx_bus_link_if

// file: hdl/tx_bus_egress_device.sv
// device end: bus reference clock, frame pulse and egress slow-speed port
// assumes link pins synchronous to clock; user streams use valid/ready
`timescale 1ns/1ps

// ***************************************************
// rail fifo
// ***************************************************
module rail_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [CW-1:0] count_q, count_d;
  logic inReady_q, inReady_d, outValid_q, outValid_d;
  logic push, pop;
  assign push = inValid && inReady_q;
  assign pop = outReady && outValid_q;
  assign inReady = inReady_q;
  assign outValid = outValid_q;
  assign outData = mem[rdPtr_q];
  always_comb begin
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    count_d = count_q;
    if (push) begin
      wrPtr_d = (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
    end
    if (pop) begin
      rdPtr_d = (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
    end
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
    inReady_d = count_d != CW'(DEPTH);
    outValid_d = count_d != '0;
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      inReady_q <= 1'b1;
      outValid_q <= 1'b0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
      inReady_q <= inReady_d;
      outValid_q <= outValid_d;
    end
  end
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end
endmodule : rail_fifo

// ***************************************************
// device end
// ***************************************************
module tx_bus_egress_device #(
  parameter int FRAME_CYCLES = tbus_pkg::FRAME_PERIOD_CYCLES,
  parameter int FIFO_DEPTH = tbus_pkg::FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic busEnable,
  input wire logic slowEnable,
  input wire logic insertMode,
  tx_bus_link_if.device link,
  output logic [tbus_pkg::RAIL_WIDTH-1:0] insData,
  output logic insValid,
  input wire logic insReady,
  output logic insOverrun,
  input wire logic [tbus_pkg::RAIL_WIDTH-1:0] extData,
  input wire logic extValid,
  output logic extReady
);
  import tbus_pkg::*;
  localparam int FW = $clog2(FRAME_CYCLES);
  role_t role_q, role_d;
  logic [NCO_WIDTH-1:0] nco_q, nco_d;
  logic [NCO_WIDTH:0] ncoSum;
  logic refClk_q, refClk_d;
  logic [FW-1:0] frameCnt_q, frameCnt_d;
  logic framePulse_q, framePulse_d;
  logic [3:0] half_q, half_d;
  logic portClk_q, portClk_d, portRise;
  logic clkIn_q, clkPrev_q, posIn_q, negIn_q, portFall;
  logic overrun_q, overrun_d;
  logic [RAIL_WIDTH-1:0] rails_q, rails_d;
  logic fifoInValid, fifoInReady, fifoOutValid, fifoOutReady;
  logic [RAIL_WIDTH-1:0] fifoInData, fifoOutData;
  typedef struct packed {
    logic refPos, refPosOe, neg, negOe, clk, clkOe, fp, fpOe;
  } pins_t;
  pins_t pins_d, pins_q;

  // ***************************************************
  // timing from the synthesizer
  // ***************************************************
  always_comb begin
    if (slowEnable) begin
      role_d = insertMode ? ROLE_INSERT : ROLE_EXTRACT;
    end else if (busEnable) begin
      role_d = ROLE_BUS;
    end else begin
      role_d = ROLE_IDLE;
    end
    ncoSum = {1'b0, nco_q} + {1'b0, REF_NCO_INC};
    if (ncoSum >= REF_NCO_MOD) begin
      nco_d = NCO_WIDTH'(ncoSum - REF_NCO_MOD);
      refClk_d = !refClk_q;
    end else begin
      nco_d = NCO_WIDTH'(ncoSum);
      refClk_d = refClk_q;
    end
    frameCnt_d = (frameCnt_q == FW'(FRAME_CYCLES - 1)) ? '0 : frameCnt_q + 1'b1;
    framePulse_d = frameCnt_q == FW'(FRAME_CYCLES - 1);
    portRise = 1'b0;
    if (role_q != ROLE_EXTRACT) begin
      half_d = '0;
      portClk_d = 1'b0;
    end else if (half_q == SLOW_CLK_HALF_CYCLES - 4'h1) begin
      half_d = '0;
      portClk_d = !portClk_q;
      portRise = !portClk_q;
    end else begin
      half_d = half_q + 4'h1;
      portClk_d = portClk_q;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      role_q <= ROLE_IDLE;
      nco_q <= REF_NCO_RESET;
      refClk_q <= 1'b0;
      frameCnt_q <= '0;
      framePulse_q <= 1'b0;
      half_q <= '0;
      portClk_q <= 1'b0;
    end else begin
      role_q <= role_d;
      nco_q <= nco_d;
      refClk_q <= refClk_d;
      frameCnt_q <= frameCnt_d;
      framePulse_q <= framePulse_d;
      half_q <= half_d;
      portClk_q <= portClk_d;
    end
  end

  // ***************************************************
  // slow-speed data path
  // ***************************************************
  // falling edge of far clock
  assign portFall = clkPrev_q && !clkIn_q && (role_q == ROLE_INSERT);
  always_comb begin
    if (role_q == ROLE_INSERT) begin
      fifoInData = {posIn_q, negIn_q};
      fifoInValid = portFall;
      fifoOutReady = insReady;
    end else begin
      fifoInData = extData;
      fifoInValid = extValid && (role_q == ROLE_EXTRACT);
      fifoOutReady = portRise;
    end
    overrun_d = portFall && !fifoInReady;
    rails_d = rails_q;
    if (role_q != ROLE_EXTRACT) begin
      rails_d = RAIL_IDLE;
    end else if (portRise) begin
      rails_d = fifoOutValid ? fifoOutData : RAIL_IDLE;
    end
  end
  rail_fifo #(.WIDTH(RAIL_WIDTH), .DEPTH(FIFO_DEPTH)) fifo (
    .clock(clock),
    .rst(rst),
    .inData(fifoInData),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .outData(fifoOutData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady)
  );
  assign insData = fifoOutData;
  assign insValid = fifoOutValid && (role_q == ROLE_INSERT);
  assign extReady = fifoInReady && (role_q == ROLE_EXTRACT);
  assign insOverrun = overrun_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      clkIn_q <= 1'b0;
      clkPrev_q <= 1'b0;
      posIn_q <= 1'b0;
      negIn_q <= 1'b0;
      overrun_q <= 1'b0;
      rails_q <= RAIL_IDLE;
    end else begin
      clkIn_q <= link.clkLine;
      clkPrev_q <= clkIn_q;
      posIn_q <= link.posLine;
      negIn_q <= link.negLine;
      overrun_q <= overrun_d;
      rails_q <= rails_d;
    end
  end

  // ***************************************************
  // pin drivers
  // ***************************************************
  always_comb begin
    pins_d = '0;
    unique case (role_q)
      ROLE_IDLE, ROLE_INSERT: begin
      end
      ROLE_BUS: begin
        pins_d.refPos = refClk_q;
        pins_d.refPosOe = 1'b1;
        pins_d.fp = framePulse_q;
        pins_d.fpOe = 1'b1;
      end
      ROLE_EXTRACT: begin
        pins_d.refPos = rails_q[1];
        pins_d.refPosOe = 1'b1;
        pins_d.neg = rails_q[0];
        pins_d.negOe = 1'b1;
        pins_d.clk = portClk_q;
        pins_d.clkOe = 1'b1;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pins_q <= '0;
    end else begin
      pins_q <= pins_d;
    end
  end

  assign link.refPosDevOut = pins_q.refPos;
  assign link.refPosDevOe = pins_q.refPosOe;
  assign link.negDevOut = pins_q.neg;
  assign link.negDevOe = pins_q.negOe;
  assign link.clkDevOut = pins_q.clk;
  assign link.clkDevOe = pins_q.clkOe;
  assign link.fpDevOut = pins_q.fp;
  assign link.fpDevOe = pins_q.fpOe;
endmodule : tx_bus_egress_device

// file: hdl/tx_bus_far_end.sv
// far end: bus source timing follower and slow-speed test equipment
// assumes the same clock as the device and synchronous link pins
`timescale 1ns/1ps
module tx_bus_far_end (
  input wire logic clock,
  input wire logic rst,
  input wire logic realignmentEnabled,
  input wire logic farInsertMode,
  tx_bus_link_if.far link,
  input wire logic [tbus_pkg::RAIL_WIDTH-1:0] srcData,
  input wire logic srcValid,
  output logic srcReady,
  output logic [tbus_pkg::RAIL_WIDTH-1:0] sinkData,
  output logic sinkValid,
  output logic busStrobe,
  output logic frameStart
);
  import tbus_pkg::*;

  logic refIn_q, refPrev_q, fpIn_q, fpPrev_q;
  logic clkIn_q, clkPrev_q, posIn_q, negIn_q;
  logic busStrobe_q, busStrobe_d, frameStart_q, frameStart_d;
  logic [3:0] half_q, half_d;
  logic portClk_q, portClk_d, portRise;
  logic [RAIL_WIDTH-1:0] rails_q, rails_d, sink_q, sink_d;
  logic railsOe_q, railsOe_d, srcReady_q, srcReady_d, sinkValid_q, sinkValid_d;

  // ***************************************************
  // bus source timing
  // ***************************************************
  always_comb begin
    // data timed from reference unless realigned
    busStrobe_d = realignmentEnabled ? 1'b1 : (refIn_q && !refPrev_q);
    frameStart_d = fpIn_q && !fpPrev_q;
  end

  // ***************************************************
  // slow-speed port
  // ***************************************************
  always_comb begin
    portRise = 1'b0;
    half_d = '0;
    portClk_d = 1'b0;
    rails_d = rails_q;
    srcReady_d = 1'b0;
    railsOe_d = farInsertMode;
    sink_d = sink_q;
    sinkValid_d = 1'b0;
    if (farInsertMode) begin
      if (half_q == SLOW_CLK_HALF_CYCLES - 4'h1) begin
        portClk_d = !portClk_q;
        portRise = !portClk_q;
      end else begin
        half_d = half_q + 4'h1;
        portClk_d = portClk_q;
      end
      if (portRise) begin
        rails_d = srcValid ? srcData : RAIL_IDLE;
        srcReady_d = srcValid;
      end
    end else begin
      rails_d = RAIL_IDLE;
      // take rails a half period later
      if (clkPrev_q && !clkIn_q) begin
        sink_d = {posIn_q, negIn_q};
        sinkValid_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      refIn_q <= 1'b0;
      refPrev_q <= 1'b0;
      fpIn_q <= 1'b0;
      fpPrev_q <= 1'b0;
      clkIn_q <= 1'b0;
      clkPrev_q <= 1'b0;
      posIn_q <= 1'b0;
      negIn_q <= 1'b0;
      busStrobe_q <= 1'b0;
      frameStart_q <= 1'b0;
      half_q <= '0;
      portClk_q <= 1'b0;
      rails_q <= RAIL_IDLE;
      railsOe_q <= 1'b0;
      srcReady_q <= 1'b0;
      sink_q <= RAIL_IDLE;
      sinkValid_q <= 1'b0;
    end else begin
      refIn_q <= link.posLine;
      refPrev_q <= refIn_q;
      fpIn_q <= link.fpLine;
      fpPrev_q <= fpIn_q;
      clkIn_q <= link.clkLine;
      clkPrev_q <= clkIn_q;
      posIn_q <= link.posLine;
      negIn_q <= link.negLine;
      busStrobe_q <= busStrobe_d;
      frameStart_q <= frameStart_d;
      half_q <= half_d;
      portClk_q <= portClk_d;
      rails_q <= rails_d;
      railsOe_q <= railsOe_d;
      srcReady_q <= srcReady_d;
      sink_q <= sink_d;
      sinkValid_q <= sinkValid_d;
    end
  end

  assign link.posFarOut = rails_q[1];
  assign link.negFarOut = rails_q[0];
  assign link.posFarOe = railsOe_q;
  assign link.negFarOe = railsOe_q;
  assign link.clkFarOut = portClk_q;
  assign link.clkFarOe = railsOe_q;
  assign srcReady = srcReady_q;
  assign sinkData = sink_q;
  assign sinkValid = sinkValid_q;
  assign busStrobe = busStrobe_q;
  assign frameStart = frameStart_q;
endmodule : tx_bus_far_end

// file: tb/tx_bus_link_sva.sv
// link pin checker for the device end and the far end
// assumes FRAME_CYCLES equals the device instance parameter
`timescale 1ns/1ps
module tx_bus_link_sva #(
  parameter int FRAME_CYCLES = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic refPosDevOut,
  input wire logic refPosDevOe,
  input wire logic posFarOut,
  input wire logic negDevOut,
  input wire logic negDevOe,
  input wire logic negFarOut,
  input wire logic clkDevOut,
  input wire logic clkDevOe,
  input wire logic clkFarOut,
  input wire logic clkFarOe,
  input wire logic fpDevOut,
  input wire logic fpDevOe
);
  // ****************************
  // frame gap counter
  // ****************************
  logic [15:0] fpGap_q;
  logic [15:0] fpGap_d;
  logic fpArmed_q;
  logic fpArmed_d;

  always_comb begin
    fpGap_d = fpDevOut ? 16'h0000 : fpGap_q + 16'h0001;
    fpArmed_d = fpDevOe & (fpArmed_q | fpDevOut);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      fpGap_q <= 16'h0000;
      fpArmed_q <= 1'b0;
    end else begin
      fpGap_q <= fpGap_d;
      fpArmed_q <= fpArmed_d;
    end
  end

  // ****************************
  // assertions
  // ****************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  fp_pulse_width_a: assert property (fpDevOut |=> !fpDevOut)
    else $error("frame pulse wider than one cycle");
  fp_period_a: assert property (fpDevOut && fpArmed_q |-> fpGap_q == 16'(FRAME_CYCLES - 1))
    else $error("frame pulse period wrong");
  bus_role_a: assert property (fpDevOe |-> refPosDevOe && !clkDevOe && !negDevOe)
    else $error("frame pulse driven outside bus role");
  far_exclusive_a: assert property (clkFarOe |-> !clkDevOe && !refPosDevOe && !negDevOe)
    else $error("device drives pins while far end inserts");
  ref_high_a: assert property ($rose(refPosDevOut) && fpDevOe && $past(fpDevOe) |=>
    (refPosDevOut || !fpDevOe) ##[1:2] (!refPosDevOut || !fpDevOe))
    else $error("reference clock high phase wrong");
  ref_low_a: assert property ($fell(refPosDevOut) && fpDevOe |=>
    (!refPosDevOut || !fpDevOe) ##[1:2] (refPosDevOut || !fpDevOe))
    else $error("reference clock low phase wrong");
  ext_clock_a: assert property ($rose(clkDevOut) && clkDevOe |=>
    (clkDevOut || !clkDevOe) ##1 !clkDevOut)
    else $error("extract port clock high phase wrong");
  ext_rails_a: assert property (clkDevOe && $past(clkDevOe) && !$rose(clkDevOut) |->
    $stable(negDevOut) && $stable(refPosDevOut))
    else $error("extract rails moved off the rising port clock");
  ins_rails_a: assert property (clkFarOe && $past(clkFarOe) && !$rose(clkFarOut) |->
    $stable({posFarOut, negFarOut}))
    else $error("insert rails moved off the rising port clock");
  ins_clock_a: assert property ($fell(clkFarOut) && clkFarOe |=>
    !clkFarOut ##1 (clkFarOut || !clkFarOe))
    else $error("insert port clock low phase wrong");
endmodule : tx_bus_link_sva

// file: tb/tx_bus_timing_and_egress_port_test.sv
// self-checking bench: device end and far end joined by the link interface
// assumes the design files and the link checker are compiled first
`timescale 1ns/1ps
module tx_bus_timing_and_egress_port_test;
  import tbus_pkg::*;
  localparam int FRAME = 16;
  logic clock, rst, busEnable, slowEnable, insertMode, realignmentEnabled, farInsertMode;
  logic insValid, insReady, insOverrun, extValid, extReady, srcValid, srcReady;
  logic sinkValid, busStrobe, frameStart, fpSeen, busPhase, insStall, insRand, extFull;
  logic [RAIL_WIDTH-1:0] insData, extData, srcData, sinkData;
  logic [1:0] extQ[$];
  logic [1:0] insQ[$];
  logic [15:0] hits;
  int fails, samples_checked, overruns, tick, gap;

  tx_bus_link_if link();
  tx_bus_egress_device #(.FRAME_CYCLES(FRAME), .FIFO_DEPTH(FIFO_DEPTH)) u_tx_bus_egress_device (
    .clock(clock), .rst(rst), .busEnable(busEnable), .slowEnable(slowEnable),
    .insertMode(insertMode), .link(link), .insData(insData), .insValid(insValid),
    .insReady(insReady), .insOverrun(insOverrun), .extData(extData), .extValid(extValid),
    .extReady(extReady));
  tx_bus_far_end u_tx_bus_far_end (
    .clock(clock), .rst(rst), .realignmentEnabled(realignmentEnabled),
    .farInsertMode(farInsertMode), .link(link), .srcData(srcData), .srcValid(srcValid),
    .srcReady(srcReady), .sinkData(sinkData), .sinkValid(sinkValid),
    .busStrobe(busStrobe), .frameStart(frameStart));
  tx_bus_link_sva #(.FRAME_CYCLES(FRAME)) u_tx_bus_link_sva (
    .clock(clock), .rst(rst), .refPosDevOut(link.refPosDevOut),
    .refPosDevOe(link.refPosDevOe), .posFarOut(link.posFarOut), .negDevOut(link.negDevOut),
    .negDevOe(link.negDevOe), .negFarOut(link.negFarOut), .clkDevOut(link.clkDevOut),
    .clkDevOe(link.clkDevOe), .clkFarOut(link.clkFarOut), .clkFarOe(link.clkFarOe),
    .fpDevOut(link.fpDevOut), .fpDevOe(link.fpDevOe));

  always #5 clock = ~clock;

  // ****************************
  // helpers
  // ****************************
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  task automatic check(input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: expected %0h got %0h", $time, exp, got);
    end
  endtask : check

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  task automatic countStrobe(input int n);
    hits = 16'h0000;
    repeat (n) begin
      @(negedge clock);
      hits += 16'(busStrobe);
    end
  endtask : countStrobe

  task automatic sendExt(input logic [1:0] d);
    int k;
    extData = d;
    extValid = 1'b1;
    k = 0;
    while (extReady !== 1'b1 && k < 200) begin
      extFull = 1'b1;
      cyc(1);
      k++;
    end
    if (k == 200) fails++;
    extQ.push_back(d);
    cyc(1);
  endtask : sendExt

  task automatic sendSrc(input logic [1:0] d);
    int k;
    srcData = d;
    srcValid = 1'b1;
    k = 0;
    while (srcReady !== 1'b1 && k < 200) begin
      cyc(1);
      k++;
    end
    if (k == 200) fails++;
    insQ.push_back(d);
    cyc(1);
  endtask : sendSrc

  // ****************************
  // output monitors and timeout
  // ****************************
  always @(negedge clock) insReady <= insStall ? 1'b0 : (insRand ? 1'($urandom) : 1'b1);

  always @(posedge clock) begin
    tick++;
    gap++;
    if (tick == 10000) begin
      fails++;
      close_out();
    end
    if (!busPhase) fpSeen = 1'b0;
    if (frameStart) begin
      if (fpSeen) check(16'(FRAME), 16'(gap));
      fpSeen = busPhase;
      gap = 0;
    end
    if (insOverrun) overruns++;
    if (sinkValid && sinkData !== 2'h0)
      check(extQ.size() ? {14'h0, extQ.pop_front()} : 16'hFFFF, {14'h0, sinkData});
    if (insValid && insReady && insData !== 2'h0)
      check(insQ.size() ? {14'h0, insQ.pop_front()} : 16'hFFFF, {14'h0, insData});
  end

  // ****************************
  // main sequence
  // ****************************
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    {busEnable, slowEnable, insertMode, realignmentEnabled, farInsertMode} = 5'h00;
    {extValid, srcValid, fpSeen, busPhase, insRand, extFull} = 6'h00;
    insStall = 1'b0;
    insReady = 1'b0;
    extData = 2'h0;
    srcData = 2'h0;
    {fails, samples_checked, overruns, tick, gap} = '0;
    void'($urandom(32'hD759));
    cyc(20);
    rst = 1'b0;
    cyc(4);
    busEnable = 1'b1;
    busPhase = 1'b1;
    cyc(10);
    countStrobe(500);
    check(16'h0061, (hits == 16'h0062) ? 16'h0061 : hits);
    realignmentEnabled = 1'b1;
    cyc(4);
    countStrobe(50);
    check(16'h0032, hits);
    realignmentEnabled = 1'b0;
    busPhase = 1'b0;
    slowEnable = 1'b1;
    cyc(4);
    check(16'h0001, {14'h0, link.fpDevOe, link.clkDevOe});
    repeat (20) sendExt(2'(1 + $urandom % 3));
    extValid = 1'b0;
    check(16'h0001, {15'h0, extFull});
    cyc(150);
    check(16'h0000, 16'(extQ.size()));
    slowEnable = 1'b0;
    busEnable = 1'b0;
    cyc(6);
    insStall = 1'b1;
    farInsertMode = 1'b1;
    insertMode = 1'b1;
    slowEnable = 1'b1;
    cyc(80);
    check(16'h0001, {15'h0, overruns > 0});
    insStall = 1'b0;
    cyc(20);
    overruns = 0;
    insRand = 1'b1;
    repeat (20) sendSrc(2'(1 + $urandom % 3));
    srcValid = 1'b0;
    cyc(100);
    check(16'h0000, 16'(insQ.size()));
    check(16'h0000, 16'(overruns));
    farInsertMode = 1'b0;
    slowEnable = 1'b0;
    cyc(8);
    close_out();
  end
endmodule : tx_bus_timing_and_egress_port_test
